/* verilog/nvs_seq.sv */
/*
 * Store and recall sequencer of a serial nonvolatile static memory, with
 * Wishbone registers, the bidirectional busy pin and the serial command port.
 * Assumes the array write path pulses I_MEM_WR and honours O_MEM_BLOCK.
 */
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns
`include "nvs_defines.svh"

module nvs_seq #(
    parameter bit HAS_BUSY_PIN = 1'b1,
    parameter bit HAS_PF_STORE = 1'b1,
    parameter bit HAS_PIN_STORE = 1'b1,
    parameter int unsigned STORE_CYC = `NVS_STORE_CYC,
    parameter int unsigned RECALL_CYC = `NVS_RECALL_CYC,
    parameter int unsigned PUP_RECALL_CYC = `NVS_PUP_RECALL_CYC,
    parameter int unsigned RELEASE_CYC = `NVS_RELEASE_CYC,
    parameter int unsigned GUARD_CYC = `NVS_GUARD_CYC,
    parameter int unsigned DELAY_CYC = `NVS_REQ_DELAY_CYC
) (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_NRST,
    // Wishbone slave
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [7:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    // Serial port
    input wire logic I_SCK,
    input wire logic I_CS_N,
    input wire logic I_SI,
    output logic O_SO,
    output logic O_SO_OE,
    // Power fail and busy pin
    input wire logic I_PWR_FAIL,
    input wire logic I_STORE_BUSY_N,
    output logic O_STORE_BUSY_N,
    output logic O_STORE_BUSY_N_OE,
    // Memory array
    input wire logic I_MEM_WR,
    output logic O_MEM_BLOCK,
    output logic O_NV_ERASE,
    output logic O_NV_PROGRAM,
    output logic O_SRAM_CLEAR,
    output logic O_NV_LOAD,
    output logic [7:0] O_OPCODE,
    output logic O_OPCODE_VLD
);

    localparam logic [15:0] STORE_LAST = 16'(STORE_CYC - 1);

    localparam nvs_pkg::nvs_seq_s RST_VAL = '{state: nvs_pkg::ST_CLEAR,
        src: nvs_pkg::SRC_PUP, cnt: 16'(PUP_RECALL_CYC / 2), len: 16'h0000,
        dirty: 1'b0, pfen: HAS_PF_STORE & `NVS_PFEN_RST, did_store: 1'b0,
        pf_m: 1'b0, pf_s: 1'b0, bz_m: 1'b1, bz_s: 1'b1, ack: 1'b0,
        rdat: 32'h0000_0000};

    // =====================================================================
    // Parameter check
    generate
        if (STORE_CYC < 2 || RECALL_CYC < 2 || PUP_RECALL_CYC < 2 || RELEASE_CYC < 1 ||
            DELAY_CYC < 1 || GUARD_CYC < `NVS_SETTLE_CYC || STORE_CYC > 65535 ||
            RECALL_CYC > 65535 || PUP_RECALL_CYC > 65535 || GUARD_CYC > 65535 ||
            DELAY_CYC > 65535 || RELEASE_CYC > 65535)
        begin : g_bad_param
            $error("nvs_seq: cycle count out of range");
        end
    endgenerate

    nvs_pkg::nvs_seq_s r_ff;
    nvs_pkg::nvs_seq_s nxt_r;
    nvs_pkg::nvs_state_e ns;
    logic [7:0] rx_op;
    logic rx_vld;
    logic rx_mode3;
    logic wr_ctrl;
    logic cmd_store;
    logic cmd_recall;
    logic cmd_pf_on;
    logic cmd_pf_off;
    logic pin_low;
    logic pf_go;
    logic done;
    logic busy;
    logic in_store;
    logic block;

    // =====================================================================
    // Interval of each timed state
    function automatic logic [15:0] cyc_of(input nvs_pkg::nvs_state_e s, input nvs_pkg::nvs_src_e src);
        int unsigned rc;
        rc = (src == nvs_pkg::SRC_PUP) ? PUP_RECALL_CYC : RECALL_CYC;
        case (s)
            nvs_pkg::ST_PIN_WAIT: cyc_of = 16'(DELAY_CYC);
            nvs_pkg::ST_ERASE: cyc_of = 16'(STORE_CYC / 2);
            nvs_pkg::ST_PROGRAM: cyc_of = 16'(STORE_CYC - STORE_CYC / 2);
            nvs_pkg::ST_HOLD_LOW: cyc_of = 16'(`NVS_SETTLE_CYC);
            nvs_pkg::ST_RELEASE: cyc_of = 16'(RELEASE_CYC);
            nvs_pkg::ST_GUARD: cyc_of = 16'(GUARD_CYC);
            nvs_pkg::ST_CLEAR: cyc_of = 16'(rc / 2);
            nvs_pkg::ST_LOAD: cyc_of = 16'(rc - rc / 2);
            default: cyc_of = 16'h0000;
        endcase
    endfunction : cyc_of

    // =====================================================================
    // Serial front end
    nvs_spi_rx u_rx (
        .i_clk(I_CLK),
        .i_nrst(I_NRST),
        .i_sck(I_SCK),
        .i_cs_n(I_CS_N),
        .i_si(I_SI),
        .o_opcode(rx_op),
        .o_opcode_vld(rx_vld),
        .o_mode3(rx_mode3)
    );

    // =====================================================================
    // Request decode
    always_comb
    begin
        wr_ctrl = r_ff.ack && I_WB_CYC && I_WB_STB && I_WB_WE && I_WB_SEL[0] && I_WB_ADR == `NVS_CTRL_OFS;
        cmd_store = (rx_vld && rx_op == `NVS_OP_STORE) || (wr_ctrl && I_WB_DAT[`NVS_CTRL_STORE_BIT]);
        cmd_recall = (rx_vld && rx_op == `NVS_OP_RECALL) || (wr_ctrl && I_WB_DAT[`NVS_CTRL_RECALL_BIT]);
        cmd_pf_on = (rx_vld && rx_op == `NVS_OP_PF_ON) || (wr_ctrl && I_WB_DAT[`NVS_CTRL_PF_ON_BIT]);
        cmd_pf_off = (rx_vld && rx_op == `NVS_OP_PF_OFF) || (wr_ctrl && I_WB_DAT[`NVS_CTRL_PF_OFF_BIT]);
        pin_low = HAS_BUSY_PIN && HAS_PIN_STORE && !r_ff.bz_s;
        pf_go = HAS_PF_STORE && r_ff.pfen && r_ff.pf_s;
        done = (r_ff.cnt <= 16'h0001);
        in_store = (r_ff.state == nvs_pkg::ST_ERASE) || (r_ff.state == nvs_pkg::ST_PROGRAM);
        busy = (r_ff.state != nvs_pkg::ST_IDLE) && (r_ff.state != nvs_pkg::ST_GUARD);
        block = (r_ff.state != nvs_pkg::ST_IDLE) || r_ff.pf_s;
    end

    // =====================================================================
    // Sequencer and registers
    always_comb
    begin
        nxt_r = r_ff;
        ns = r_ff.state;
        nxt_r.pf_m = I_PWR_FAIL;
        nxt_r.pf_s = r_ff.pf_m;
        nxt_r.bz_m = I_STORE_BUSY_N;
        nxt_r.bz_s = r_ff.bz_m;
        nxt_r.cnt = (r_ff.cnt != 16'h0000) ? r_ff.cnt - 16'h0001 : 16'h0000;
        nxt_r.len = in_store ? r_ff.len + 16'h0001 : 16'h0000;

        // Wishbone: one wait state, ack for one cycle
        nxt_r.ack = I_WB_CYC && I_WB_STB && !r_ff.ack;
        if (I_WB_CYC && I_WB_STB && !r_ff.ack)
        begin
            nxt_r.rdat = 32'h0000_0000;
            if (I_WB_ADR == `NVS_STAT_OFS)
            begin
                nxt_r.rdat[`NVS_STAT_BUSY_BIT] = busy;
                nxt_r.rdat[`NVS_STAT_DIRTY_BIT] = r_ff.dirty;
                nxt_r.rdat[`NVS_STAT_PFEN_BIT] = r_ff.pfen;
                nxt_r.rdat[`NVS_STAT_MODE3_BIT] = rx_mode3;
                nxt_r.rdat[`NVS_STAT_BLOCK_BIT] = block;
            end
        end

        // Volatile power-fail enable; absent feature keeps it off
        if (HAS_PF_STORE && cmd_pf_on)
            nxt_r.pfen = 1'b1;
        else if (HAS_PF_STORE && cmd_pf_off)
            nxt_r.pfen = 1'b0;

        case (r_ff.state)
            nvs_pkg::ST_IDLE:
            begin
                if (r_ff.pf_s)
                begin
                    nxt_r.src = nvs_pkg::SRC_PF;
                    if (pf_go && r_ff.dirty)
                        ns = nvs_pkg::ST_ERASE;
                end
                else if (cmd_store)
                begin
                    nxt_r.src = nvs_pkg::SRC_SW;
                    ns = nvs_pkg::ST_ERASE;
                end
                else if (cmd_recall)
                begin
                    nxt_r.src = nvs_pkg::SRC_SW;
                    ns = nvs_pkg::ST_CLEAR;
                end
                else if (pin_low)
                begin
                    nxt_r.src = nvs_pkg::SRC_PIN;
                    ns = nvs_pkg::ST_PIN_WAIT;
                end
            end
            nvs_pkg::ST_PIN_WAIT:
            begin
                if (done)
                begin
                    nxt_r.did_store = r_ff.dirty;
                    ns = r_ff.dirty ? nvs_pkg::ST_ERASE : nvs_pkg::ST_HOLD_LOW;
                end
            end
            nvs_pkg::ST_ERASE:
            begin
                nxt_r.did_store = 1'b1;
                if (done)
                    ns = nvs_pkg::ST_PROGRAM;
            end
            nvs_pkg::ST_PROGRAM:
            begin
                if (done)
                begin
                    case (r_ff.src)
                        nvs_pkg::SRC_PIN: ns = nvs_pkg::ST_HOLD_LOW;
                        nvs_pkg::SRC_PF: ns = nvs_pkg::ST_GUARD;
                        default: ns = nvs_pkg::ST_RELEASE;
                    endcase
                end
            end
            nvs_pkg::ST_HOLD_LOW:
            begin
                if (done && !pin_low)
                    ns = r_ff.did_store ? nvs_pkg::ST_RELEASE : nvs_pkg::ST_IDLE;
            end
            nvs_pkg::ST_RELEASE:
            begin
                if (done)
                    ns = nvs_pkg::ST_GUARD;
            end
            nvs_pkg::ST_GUARD:
            begin
                if (done)
                    ns = nvs_pkg::ST_IDLE;
            end
            nvs_pkg::ST_CLEAR:
            begin
                if (done)
                    ns = nvs_pkg::ST_LOAD;
            end
            nvs_pkg::ST_LOAD:
            begin
                if (done)
                    ns = nvs_pkg::ST_GUARD;
            end
            default:
                ns = nvs_pkg::ST_IDLE;
        endcase

        if (ns != r_ff.state)
        begin
            nxt_r.cnt = cyc_of(ns, nxt_r.src);
            if (ns == nvs_pkg::ST_IDLE)
                nxt_r.did_store = 1'b0;
        end

        // Dirty tracking: an operation start clears, a write sets and wins
        if (ns != r_ff.state && (ns == nvs_pkg::ST_ERASE || ns == nvs_pkg::ST_CLEAR))
            nxt_r.dirty = 1'b0;
        if (I_MEM_WR)
            nxt_r.dirty = 1'b1;
        nxt_r.state = ns;
    end

    always_ff @(posedge I_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
            r_ff <= RST_VAL;
        else
            r_ff <= nxt_r;
    end

    // =====================================================================
    // Outputs
    assign O_WB_DAT = r_ff.rdat;
    assign O_WB_ACK = r_ff.ack;
    assign O_SO = 1'b0;
    assign O_SO_OE = 1'b0;
    assign O_STORE_BUSY_N = (r_ff.state == nvs_pkg::ST_RELEASE);
    assign O_STORE_BUSY_N_OE = HAS_BUSY_PIN && (busy && r_ff.state != nvs_pkg::ST_PIN_WAIT &&
        r_ff.state != nvs_pkg::ST_HOLD_LOW);
    assign O_MEM_BLOCK = block;
    assign O_NV_ERASE = (r_ff.state == nvs_pkg::ST_ERASE);
    assign O_NV_PROGRAM = (r_ff.state == nvs_pkg::ST_PROGRAM);
    assign O_SRAM_CLEAR = (r_ff.state == nvs_pkg::ST_CLEAR);
    assign O_NV_LOAD = (r_ff.state == nvs_pkg::ST_LOAD);
    assign O_OPCODE = rx_op;
    assign O_OPCODE_VLD = rx_vld;

    // =====================================================================
    // Checks
    a_erase_first: assert property (
        @(posedge I_CLK) disable iff (!I_NRST)
        $rose(r_ff.state == nvs_pkg::ST_PROGRAM) |-> $past(r_ff.state) == nvs_pkg::ST_ERASE)
        else $error("program phase not preceded by erase");

    a_block_busy: assert property (
        @(posedge I_CLK) disable iff (!I_NRST)
        (O_NV_ERASE || O_NV_PROGRAM || O_SRAM_CLEAR || O_NV_LOAD) |-> O_MEM_BLOCK)
        else $error("memory access open during an operation");

    a_busy_shown: assert property (
        @(posedge I_CLK) disable iff (!I_NRST)
        (O_NV_ERASE || O_NV_PROGRAM || O_NV_LOAD) |->
            busy && (!HAS_BUSY_PIN || (O_STORE_BUSY_N_OE && !O_STORE_BUSY_N)))
        else $error("busy not shown during store or recall");

    a_clean_skip: assert property (
        @(posedge I_CLK) disable iff (!I_NRST)
        (r_ff.state == nvs_pkg::ST_IDLE && !r_ff.dirty && !cmd_store) |=> !O_NV_ERASE)
        else $error("conditional store ran on a clean array");

    a_cmd_store: assert property (
        @(posedge I_CLK) disable iff (!I_NRST)
        (r_ff.state == nvs_pkg::ST_IDLE && !r_ff.pf_s && cmd_store) |=> O_NV_ERASE)
        else $error("store command did not start a store");

    a_pf_block: assert property (
        @(posedge I_CLK) disable iff (!I_NRST)
        r_ff.pf_s |-> O_MEM_BLOCK)
        else $error("power fail did not block access");

    a_store_length: assert property (
        @(posedge I_CLK) disable iff (!I_NRST)
        $fell(in_store) |-> $past(r_ff.len) == STORE_LAST)
        else $error("store did not last the store time");

    a_pin_delay: assert property (
        @(posedge I_CLK) disable iff (!I_NRST)
        (r_ff.state == nvs_pkg::ST_IDLE && pin_low && !r_ff.pf_s && !cmd_store && !cmd_recall)
            |=> r_ff.state == nvs_pkg::ST_PIN_WAIT ##1 !O_NV_ERASE)
        else $error("pin store did not wait the request delay");

    a_release_drive: assert property (
        @(posedge I_CLK) disable iff (!I_NRST)
        $rose(r_ff.state == nvs_pkg::ST_RELEASE) |->
            (!HAS_BUSY_PIN || (O_STORE_BUSY_N_OE && O_STORE_BUSY_N)) ##1 !O_NV_ERASE)
        else $error("busy pin not driven high after store");

    a_guard_after: assert property (
        @(posedge I_CLK) disable iff (!I_NRST)
        $fell(r_ff.state == nvs_pkg::ST_RELEASE) |-> r_ff.state == nvs_pkg::ST_GUARD && O_MEM_BLOCK)
        else $error("no guard interval after store");

    a_recall_order: assert property (
        @(posedge I_CLK) disable iff (!I_NRST)
        $rose(O_NV_LOAD) |-> $past(O_SRAM_CLEAR) && O_MEM_BLOCK)
        else $error("load not preceded by clear");

    a_pfen_absent: assert property (
        @(posedge I_CLK) disable iff (!I_NRST)
        !HAS_PF_STORE |-> !r_ff.pfen)
        else $error("power-fail store enabled on a part without it");

endmodule : nvs_seq

/* verilog/nvs_defines.svh */
/*
 * Constants of the store and recall sequencer: timing, register map, opcodes.
 * Assumes a 125 MHz core clock and a Wishbone register bus with 32-bit data.
 */
`ifndef NVS_DEFINES_SVH
`define NVS_DEFINES_SVH

// =====================================================================
// Timing
`define NVS_CLK_PERIOD_NS 8
`define NVS_CYC_CEIL(t) (((t) + `NVS_CLK_PERIOD_NS - 1) / `NVS_CLK_PERIOD_NS)
`define NVS_CYC_FLOOR(t) ((t) / `NVS_CLK_PERIOD_NS)
`define NVS_STORE_TIME_NS 8000
`define NVS_RECALL_TIME_NS 1600
`define NVS_PUP_RECALL_TIME_NS 16000
`define NVS_RELEASE_TIME_NS 80
`define NVS_GUARD_TIME_NS 400
`define NVS_REQ_DELAY_TIME_NS 800
`define NVS_STORE_CYC `NVS_CYC_CEIL(`NVS_STORE_TIME_NS)
`define NVS_RECALL_CYC `NVS_CYC_CEIL(`NVS_RECALL_TIME_NS)
`define NVS_PUP_RECALL_CYC `NVS_CYC_CEIL(`NVS_PUP_RECALL_TIME_NS)
`define NVS_RELEASE_CYC `NVS_CYC_FLOOR(`NVS_RELEASE_TIME_NS)
`define NVS_GUARD_CYC `NVS_CYC_CEIL(`NVS_GUARD_TIME_NS)
`define NVS_REQ_DELAY_CYC `NVS_CYC_CEIL(`NVS_REQ_DELAY_TIME_NS)
`define NVS_SETTLE_CYC 3

// =====================================================================
// Registers
`define NVS_CTRL_OFS 8'h00
`define NVS_STAT_OFS 8'h04
`define NVS_CTRL_STORE_BIT 0
`define NVS_CTRL_RECALL_BIT 1
`define NVS_CTRL_PF_ON_BIT 2
`define NVS_CTRL_PF_OFF_BIT 3
`define NVS_STAT_BUSY_BIT 0
`define NVS_STAT_DIRTY_BIT 1
`define NVS_STAT_PFEN_BIT 2
`define NVS_STAT_MODE3_BIT 3
`define NVS_STAT_BLOCK_BIT 4
`define NVS_PFEN_RST 1'b1

// =====================================================================
// Special opcodes
`define NVS_OP_STORE 8'hA1
`define NVS_OP_RECALL 8'hA2
`define NVS_OP_PF_ON 8'hA3
`define NVS_OP_PF_OFF 8'hA4

`endif

/* verilog/nvs_pkg.sv */
/*
 * Types of the store and recall sequencer.
 * Assumes nvs_defines.svh holds the numbers.
 */
package nvs_pkg;

    typedef enum logic [3:0] {
        ST_IDLE, ST_PIN_WAIT, ST_ERASE, ST_PROGRAM, ST_HOLD_LOW,
        ST_RELEASE, ST_GUARD, ST_CLEAR, ST_LOAD
    } nvs_state_e;

    typedef enum logic [1:0] {SRC_PUP, SRC_SW, SRC_PIN, SRC_PF} nvs_src_e;

    typedef struct packed {
        nvs_state_e state;
        nvs_src_e src;
        logic [15:0] cnt;
        logic [15:0] len;
        logic dirty;
        logic pfen;
        logic did_store;
        logic pf_m;
        logic pf_s;
        logic bz_m;
        logic bz_s;
        logic ack;
        logic [31:0] rdat;
    } nvs_seq_s;

    typedef struct packed {
        logic sck_m, sck_s, sck_d;
        logic cs_m, cs_s, cs_d;
        logic si_m, si_s;
        logic sel;
        logic mode3;
        logic [3:0] bits;
        logic [7:0] sh;
        logic [7:0] op;
        logic vld;
    } nvs_rx_s;

endpackage : nvs_pkg

/* verilog/nvs_spi_rx.sv */
/*
 * Serial slave front end: samples SCK, CS and SI on the core clock and
 * delivers the first byte of each frame as the opcode.
 * Assumes SCK is at least four times slower than the core clock.
 */
`timescale 1ns/1ns
`include "nvs_defines.svh"

module nvs_spi_rx (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Serial pins
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_si,
    // Decoded frame
    output logic [7:0] o_opcode,
    output logic o_opcode_vld,
    output logic o_mode3
);

    nvs_pkg::nvs_rx_s r_ff;
    nvs_pkg::nvs_rx_s nxt_r;

    localparam nvs_pkg::nvs_rx_s RST_VAL = '{sck_m: 1'b0, sck_s: 1'b0, sck_d: 1'b0,
        cs_m: 1'b1, cs_s: 1'b1, cs_d: 1'b1, si_m: 1'b0, si_s: 1'b0, sel: 1'b0,
        mode3: 1'b0, bits: 4'h0, sh: 8'h00, op: 8'h00, vld: 1'b0};

    // =====================================================================
    // Frame decode
    always_comb
    begin
        nxt_r = r_ff;
        nxt_r.sck_m = i_sck;
        nxt_r.sck_s = r_ff.sck_m;
        nxt_r.sck_d = r_ff.sck_s;
        nxt_r.cs_m = i_cs_n;
        nxt_r.cs_s = r_ff.cs_m;
        nxt_r.cs_d = r_ff.cs_s;
        nxt_r.si_m = i_si;
        nxt_r.si_s = r_ff.si_m;
        nxt_r.vld = 1'b0;
        if (r_ff.cs_d && !r_ff.cs_s)
        begin
            nxt_r.sel = 1'b1;
            nxt_r.bits = 4'h0;
            nxt_r.mode3 = r_ff.sck_s;
        end
        else if (r_ff.cs_s)
        begin
            nxt_r.sel = 1'b0;
        end
        else if (r_ff.sel && r_ff.sck_s && !r_ff.sck_d && r_ff.bits != 4'h8)
        begin
            nxt_r.sh = {r_ff.sh[6:0], r_ff.si_s};
            nxt_r.bits = r_ff.bits + 4'h1;
            if (r_ff.bits == 4'h7)
            begin
                nxt_r.op = {r_ff.sh[6:0], r_ff.si_s};
                nxt_r.vld = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            r_ff <= RST_VAL;
        else
            r_ff <= nxt_r;
    end

    assign o_opcode = r_ff.op;
    assign o_opcode_vld = r_ff.vld;
    assign o_mode3 = r_ff.mode3;

    a_mode_capture: assert property (
        @(posedge i_clk) disable iff (!i_nrst)
        (r_ff.cs_d && !r_ff.cs_s) |=> (r_ff.mode3 == $past(r_ff.sck_s)))
        else $error("serial mode not taken from clock level at select");

endmodule : nvs_spi_rx

/* bench/nvs_spi_master.sv */
/* SPI master model: one opcode per select, MSB first, 64 ns clock.
   Assumes the slave never drives the serial output back. */
`timescale 1ns/1ns
module nvs_spi_master (
    // Serial pins
    output logic o_sck,
    output logic o_cs_n,
    output logic o_si
);
    // ====================
    // Frame
    initial
    begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b1;
    end
    task send(input logic [7:0] op, input logic m3);
        o_sck <= m3;
        #64 o_cs_n <= 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            #32 o_sck <= 1'b0;
            o_si <= op[i];
            #32 o_sck <= 1'b1;
        end
        #32 o_sck <= m3;
        o_si <= ~op[0];
        #32 o_cs_n <= 1'b1;
    endtask : send
endmodule : nvs_spi_master

/* bench/testbench.sv */
/* Bench for nvs_seq with short counts and the busy pin wire.
   Assumes the SPI master model drives the serial pins. */
`timescale 1ns/1ns
`include "nvs_defines.svh"
module testbench;
    logic I_CLK = 1'b0, I_NRST = 1'b0, cyc = 1'b0, we = 1'b0, pf = 1'b0, pin_lo = 1'b0, mem_wr = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000, rdat, q;
    logic [31:0] ers_n = 32'h0000_0000, op_n = 32'h0000_0000, e;
    logic ack, bo, boe, blk, ers, prg, clr, ld, sck, cs_n, si, so, soe, opv;
    logic [7:0] op;
    int n_fail = 0, checks = 0, cyc_n = 0;
    wire busy_w = boe ? bo : ~pin_lo;
    wire [6:0] ev = {ld, clr, boe & bo, prg, ers, blk, ~blk};
    always #4 I_CLK = ~I_CLK;
    always @(posedge I_CLK)
    begin
        ers_n <= ers_n + 32'(ers);
        op_n <= op_n + 32'(opv);
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000)
        begin
            n_fail++;
            results();
        end
    end
    nvs_spi_master nvs_spi_master_inst (.o_sck(sck), .o_cs_n(cs_n), .o_si(si));
    nvs_seq #(.STORE_CYC(20), .RECALL_CYC(10), .PUP_RECALL_CYC(10), .RELEASE_CYC(2), .GUARD_CYC(4),
        .DELAY_CYC(4)) nvs_seq_inst (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_WB_CYC(cyc), .I_WB_STB(cyc),
        .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
        .I_SCK(sck), .I_CS_N(cs_n), .I_SI(si), .O_SO(so), .O_SO_OE(soe), .I_PWR_FAIL(pf),
        .I_STORE_BUSY_N(busy_w), .O_STORE_BUSY_N(bo), .O_STORE_BUSY_N_OE(boe), .I_MEM_WR(mem_wr),
        .O_MEM_BLOCK(blk), .O_NV_ERASE(ers), .O_NV_PROGRAM(prg), .O_SRAM_CLEAR(clr), .O_NV_LOAD(ld),
        .O_OPCODE(op), .O_OPCODE_VLD(opv));
    // ====================
    // Shared tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge I_CLK);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        dat <= d;
        @(posedge I_CLK);
        while (ack !== 1'b1)
            @(posedge I_CLK);
        q = rdat;
        cyc <= 1'b0;
        @(posedge I_CLK);
    endtask : wb
    task wt(input int b);
        int n;
        n = 0;
        @(negedge I_CLK);
        while (ev[b] !== 1'b1 && n < 400)
        begin
            @(negedge I_CLK);
            n++;
        end
        chk(32'(ev[b]), 32'h1);
    endtask : wt
    task wr_pulse;
        @(posedge I_CLK);
        mem_wr <= 1'b1;
        @(posedge I_CLK);
        mem_wr <= 1'b0;
    endtask : wr_pulse
    // ====================
    // Scenarios
    task t_pup;
        @(negedge I_CLK);
        chk(32'(clr & blk & boe & ~bo), 32'h1);
        wt(6);
        wt(0);
        wb(1'b0, `NVS_STAT_OFS, 32'h0);
        chk(q, 32'h4);
        $display("power-up recall done");
    endtask : t_pup
    task t_sw;
        nvs_spi_master_inst.send(`NVS_OP_STORE, 1'b0);
        wt(2);
        chk(32'(blk & boe & ~bo), 32'h1);
        wb(1'b0, `NVS_STAT_OFS, 32'h0);
        chk(q, 32'h15);
        wt(3);
        wt(4);
        wt(0);
        wb(1'b1, `NVS_CTRL_OFS, 32'h1);
        wt(2);
        wt(0);
        $display("software store done");
    endtask : t_sw
    task t_pf;
        nvs_spi_master_inst.send(`NVS_OP_PF_OFF, 1'b1);
        wr_pulse();
        e = ers_n;
        pf <= 1'b1;
        repeat (40) @(posedge I_CLK);
        chk(ers_n - e, 32'h0);
        wb(1'b0, `NVS_STAT_OFS, 32'h0);
        chk(q, 32'h1A);
        nvs_spi_master_inst.send(`NVS_OP_PF_ON, 1'b0);
        wt(2);
        wt(3);
        repeat (40) @(posedge I_CLK);
        e = ers_n;
        repeat (40) @(posedge I_CLK);
        chk(ers_n - e, 32'h0);
        pf <= 1'b0;
        wt(0);
        wb(1'b1, `NVS_CTRL_OFS, 32'h8);
        wb(1'b0, `NVS_STAT_OFS, 32'h0);
        chk(q, 32'h0);
        wb(1'b1, `NVS_CTRL_OFS, 32'h4);
        wb(1'b0, `NVS_STAT_OFS, 32'h0);
        chk(q, 32'h4);
        $display("power fail store done");
    endtask : t_pf
    task t_pin;
        wr_pulse();
        repeat (8) @(posedge I_CLK);
        pin_lo <= 1'b1;
        wt(2);
        @(posedge I_CLK);
        pin_lo <= 1'b0;
        wt(4);
        wt(0);
        $display("pin store done");
    endtask : t_pin
    task t_rc;
        wb(1'b1, `NVS_CTRL_OFS, 32'h2);
        wt(5);
        wt(6);
        wt(0);
        wb(1'b0, 8'h10, 32'h0);
        chk(q, 32'h0);
        nvs_spi_master_inst.send(`NVS_OP_RECALL, 1'b1);
        wt(6);
        wt(0);
        nvs_spi_master_inst.send(8'h3C, 1'b0);
        chk(32'(op), 32'h3C);
        chk(32'({blk, soe, so}), 32'h0);
        chk(op_n, 32'h5);
        $display("recall done");
    endtask : t_rc
    task results;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results
    initial
    begin
        repeat (12) @(posedge I_CLK);
        I_NRST <= 1'b1;
        t_pup();
        t_sw();
        t_pf();
        t_pin();
        t_rc();
        results();
    end
endmodule : testbench
